// ===== hdl/lane_disparity.sv
/*
 * Per-lane disparity tracker for the transmit stream.
 * Assumes one bit per bit_en pulse and a synchronous active-low reset.
 */
module lane_disparity (
	// Clock and reset
	input  wire logic                             clk,
	input  wire logic                             resetn,
	// Bit stream
	input  wire logic                             bit_en,
	input  wire logic                             bit_val,
	input  wire logic                             clear,
	// Result
	output logic [optlink_pkg::DISP_W-1:0]        disp_max
);

	// ==========================================================================
	// Best-start excess counters
	// Tracking the largest excess of ones and of zeros from the best start
	// gives the peak running disparity over every start point in one pass.
	logic [optlink_pkg::DISP_W-1:0] ones_reg;
	logic [optlink_pkg::DISP_W-1:0] zeros_reg;
	logic [optlink_pkg::DISP_W-1:0] ones_next;
	logic [optlink_pkg::DISP_W-1:0] zeros_next;
	logic [optlink_pkg::DISP_W-1:0] peak_reg;
	logic [optlink_pkg::DISP_W-1:0] sat;

	assign sat = {optlink_pkg::DISP_W{1'b1}};

	always_comb begin
		ones_next  = ones_reg;
		zeros_next = zeros_reg;
		if (bit_val) begin
			ones_next  = (ones_reg == sat) ? sat : ones_reg + 1'b1;
			zeros_next = (zeros_reg == '0) ? '0 : zeros_reg - 1'b1;
		end else begin
			zeros_next = (zeros_reg == sat) ? sat : zeros_reg + 1'b1;
			ones_next  = (ones_reg == '0) ? '0 : ones_reg - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn || clear) begin
			ones_reg  <= '0;
			zeros_reg <= '0;
		end else if (bit_en) begin
			ones_reg  <= ones_next;
			zeros_reg <= zeros_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn || clear) begin
			peak_reg <= '0;
		end else if (bit_en) begin
			if (ones_next > peak_reg && ones_next >= zeros_next) begin
				peak_reg <= ones_next;
			end else if (zeros_next > peak_reg) begin
				peak_reg <= zeros_next;
			end
		end
	end

	assign disp_max = peak_reg;

endmodule

// ===== hdl/optlink_host.sv
/*
 * Host-side controller for a twelve-lane parallel optical transmitter and receiver pair.
 * Assumes the device pins are driven and sampled by this module at 100 MHz, with
 * one lane bit per divider pulse; pins from the device are asynchronous.
 */
module optlink_host (
	// Clock and reset
	input  wire logic                                   clk,
	input  wire logic                                   resetn,
	// User control
	input  wire logic                                   supply_good,
	input  wire logic                                   link_reset_req,
	input  wire logic [optlink_pkg::LANES-1:0]          lane_unused,
	input  wire logic [optlink_pkg::RATE_W-1:0]         line_rate,
	input  wire logic                                   sigdet_on,
	input  wire logic                                   rx_on,
	input  wire logic                                   disp_clear,
	// User transmit data
	input  wire logic [optlink_pkg::LANES-1:0]          tx_word,
	output logic                                        tx_take,
	// User receive data and status
	output logic [optlink_pkg::LANES-1:0]               rx_word,
	output logic                                        rx_word_valid,
	output logic                                        laser_ok,
	output logic                                        signal_ch1,
	output logic                                        signal_ch12,
	output logic                                        rate_too_high,
	output logic [optlink_pkg::LANES-1:0]               lane_rate_low,
	output logic                                        link_running,
	// Device pins
	output logic [optlink_pkg::LANES-1:0]               tx_lane,
	output logic                                        dev_reset_n,
	output logic                                        sigdet_enable,
	output logic                                        rx_output_enable,
	input  wire logic [optlink_pkg::LANES-1:0]          rx_lane,
	input  wire logic                                   laser_ctrl_ok,
	input  wire logic                                   sig_present_ch1,
	input  wire logic                                   sig_present_ch12_n
);

	localparam int NSYNC = optlink_pkg::LANES + 4;

	// ==========================================================================
	// Input synchronisers
	// Three stages per pin; a change is accepted only when the second and third
	// stages agree, so a metastable first stage never reaches the logic.
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] s1_reg;
	logic [NSYNC-1:0] s2_reg;
	logic [NSYNC-1:0] s3_reg;
	logic [NSYNC-1:0] pin_reg;

	assign pin_raw = {supply_good, sig_present_ch12_n, sig_present_ch1, laser_ctrl_ok,
		rx_lane};

	genvar g;
	generate
		for (g = 0; g < NSYNC; g++) begin : g_sync
			always_ff @(posedge clk) begin
				if (!resetn) begin
					s1_reg[g]  <= 1'b0;
					s2_reg[g]  <= 1'b0;
					s3_reg[g]  <= 1'b0;
					pin_reg[g] <= 1'b0;
				end else begin
					s1_reg[g] <= pin_raw[g];
					s2_reg[g] <= s1_reg[g];
					s3_reg[g] <= s2_reg[g];
					if (s2_reg[g] == s3_reg[g]) begin
						pin_reg[g] <= s3_reg[g];
					end
				end
			end
		end
	endgenerate

	logic [optlink_pkg::LANES-1:0] rx_clean;
	logic                          lcu_clean;
	logic                          sd1_clean;
	logic                          sig_present_ch12_n_n_clean;
	logic                          supply_clean;

	assign rx_clean     = pin_reg[optlink_pkg::LANES-1:0];
	assign lcu_clean    = pin_reg[optlink_pkg::LANES];
	assign sd1_clean    = pin_reg[optlink_pkg::LANES+1];
	assign sig_present_ch12_n_n_clean = pin_reg[optlink_pkg::LANES+2];
	assign supply_clean = pin_reg[optlink_pkg::LANES+3];

	// ==========================================================================
	// Bit-rate divider
	logic [7:0] div_reg;
	logic       bit_en;

	assign bit_en = (div_reg == optlink_pkg::BIT_DIV - 8'h01);

	always_ff @(posedge clk) begin
		if (!resetn || bit_en) begin
			div_reg <= 8'h00;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end

	// ==========================================================================
	// Power sequencing
	// The device reset is held low until the supply is good and has stayed good
	// for the hold time, so the laser driver never starts on a sagging rail.
	optlink_pkg::pwr_state_e          pwr_reg;
	logic [optlink_pkg::POR_CNT_W-1:0] por_cnt_reg;
	logic                             running;

	assign running = (pwr_reg == optlink_pkg::PWR_RUN);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			pwr_reg     <= optlink_pkg::PWR_OFF;
			por_cnt_reg <= '0;
		end else if (!supply_clean || link_reset_req) begin
			pwr_reg     <= optlink_pkg::PWR_OFF;
			por_cnt_reg <= '0;
		end else begin
			unique case (pwr_reg)
				optlink_pkg::PWR_OFF: begin
					pwr_reg     <= optlink_pkg::PWR_HOLD;
					por_cnt_reg <= '0;
				end
				optlink_pkg::PWR_HOLD: begin
					if (por_cnt_reg ==
						optlink_pkg::POR_CNT_W'(optlink_pkg::POR_HOLD_CYC - 1)) begin
						pwr_reg <= optlink_pkg::PWR_RUN;
					end else begin
						por_cnt_reg <= por_cnt_reg + 1'b1;
					end
				end
				optlink_pkg::PWR_RUN: begin
					pwr_reg <= optlink_pkg::PWR_RUN;
				end
				default: begin
					pwr_reg <= optlink_pkg::PWR_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			dev_reset_n  <= 1'b0;
			link_running <= 1'b0;
		end else begin
			dev_reset_n  <= running;
			link_running <= running;
		end
	end

	// ==========================================================================
	// Transmit lanes
	// Unused lanes idle high so the device alerter shuts them off and saves
	// supply current; active lanes idle low while the link is held in reset.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tx_lane <= '0;
			tx_take <= 1'b0;
		end else begin
			tx_take <= bit_en && running;
			if (!running) begin
				tx_lane <= lane_unused;
			end else if (bit_en) begin
				tx_lane <= tx_word | lane_unused;
			end
		end
	end

	// ==========================================================================
	// Disparity and line-rate checks
	logic [optlink_pkg::DISP_W-1:0] disp [optlink_pkg::LANES];

	generate
		for (g = 0; g < optlink_pkg::LANES; g++) begin : g_lane
			lane_disparity u_disp (
				.clk     (clk),
				.resetn  (resetn),
				.bit_en  (bit_en && running && !lane_unused[g]),
				.bit_val (tx_word[g]),
				.clear   (disp_clear),
				.disp_max(disp[g])
			);

			// The receiver bound of eight times D dominates the transmitter bound of D.
			logic [optlink_pkg::DISP_W+2:0] min_rate;

			assign min_rate = {disp[g], 3'b000};

			always_ff @(posedge clk) begin
				if (!resetn) begin
					lane_rate_low[g] <= 1'b0;
				end else begin
					lane_rate_low[g] <= (min_rate > {3'b000, line_rate}) ||
						(disp[g] > line_rate);
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rate_too_high <= 1'b0;
		end else begin
			rate_too_high <= (line_rate > optlink_pkg::MAX_RATE_MBPS);
		end
	end

	// ==========================================================================
	// Receiver control and status
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sigdet_enable    <= optlink_pkg::SIGDET_EN_RST;
			rx_output_enable <= optlink_pkg::RX_OE_RST;
		end else begin
			sigdet_enable    <= sigdet_on;
			rx_output_enable <= rx_on && running;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rx_word       <= '0;
			rx_word_valid <= 1'b0;
			laser_ok      <= 1'b0;
			signal_ch1    <= 1'b0;
			signal_ch12   <= 1'b0;
		end else begin
			rx_word_valid <= bit_en && running && rx_output_enable;
			if (bit_en) begin
				rx_word <= rx_clean;
			end
			laser_ok    <= lcu_clean && running;
			signal_ch1  <= sd1_clean;
			signal_ch12 <= !sig_present_ch12_n_n_clean;
		end
	end

endmodule

// ===== shared/optlink_pkg.sv
/*
 * Constants shared by the parallel optical link controller and its lane monitor.
 * Assumes a 100 MHz system clock and the twelve-lane transmitter/receiver pair outside.
 */
package optlink_pkg;

	// ==========================================================================
	// Link geometry
	localparam int          LANES          = 12;
	localparam int          DISP_W         = 12;
	localparam int          RATE_W         = 12;

	// ==========================================================================
	// Rates
	localparam int          CLK_MHZ        = 100;
	localparam logic [11:0] MAX_RATE_MBPS  = 12'h0640;
	localparam logic [2:0]  RX_DISP_FACTOR = 3'h3;
	localparam logic [7:0]  BIT_DIV        = 8'h04;
	localparam logic [11:0] RATE_RESET     = 12'h0640;

	// ==========================================================================
	// Power-up reset hold
	localparam int          POR_HOLD_US    = 10;
	localparam int          POR_HOLD_CYC   = POR_HOLD_US * CLK_MHZ;
	localparam int          POR_CNT_W      = 11;

	// ==========================================================================
	// Reset values of the control pins
	localparam logic        SIGDET_EN_RST  = 1'b1;
	localparam logic        RX_OE_RST      = 1'b0;

	// ==========================================================================
	// Power sequencing states
	typedef enum logic [1:0] {
		PWR_OFF  = 2'b00,
		PWR_HOLD = 2'b01,
		PWR_RUN  = 2'b10
	} pwr_state_e;

endpackage

// ===== testbench/link_ctrl_checker.sv
/*
 * Port checker for optlink_host.
 * Assumes one clock domain and binding onto every optlink_host instance.
 */
module link_ctrl_checker (
	// Clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// User side
	input wire logic        supply_good,
	input wire logic        link_reset_req,
	input wire logic [11:0] lane_unused,
	input wire logic [11:0] line_rate,
	input wire logic [11:0] tx_word,
	input wire logic        tx_take,
	input wire logic        laser_ok,
	input wire logic        signal_ch1,
	input wire logic        signal_ch12,
	input wire logic        rate_too_high,
	input wire logic        link_running,
	// Device pins
	input wire logic [11:0] tx_lane,
	input wire logic        dev_reset_n,
	input wire logic        rx_output_enable,
	input wire logic        laser_ctrl_ok,
	input wire logic        sig_present_ch1,
	input wire logic        sig_present_ch12_n
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	logic [10:0] hold_cnt;

	// ==========
	// Supply good time
	always_ff @(posedge clk) begin
		if (!resetn || !supply_good || link_reset_req)
			hold_cnt <= 11'h000;
		else if (hold_cnt != 11'h7ff)
			hold_cnt <= hold_cnt + 11'h001;
	end

	// ==========
	// Properties
	a_tx_word_lanes: assert property (tx_take |->
		tx_lane == ($past(tx_word) | $past(lane_unused))) else $error("tx lanes wrong");
	a_idle_lanes_high: assert property ((!link_running && $stable(lane_unused))[*6] |->
		tx_lane == lane_unused) else $error("idle lanes wrong");
	a_rate_limit_flag: assert property ((line_rate == $past(line_rate))[*2] |->
		rate_too_high == (line_rate > optlink_pkg::MAX_RATE_MBPS)) else $error("rate flag");
	a_por_hold_time: assert property ($rose(dev_reset_n) |->
		hold_cnt >= optlink_pkg::POR_HOLD_CYC) else $error("reset released early");
	a_reset_drops_lasers: assert property (link_reset_req |-> ##[0:3] !dev_reset_n)
		else $error("device reset late");
	a_laser_fault_seen: assert property ((!laser_ctrl_ok)[*8] |-> !laser_ok)
		else $error("fault not seen");
	a_ch1_active_high: assert property ((sig_present_ch1 == $past(sig_present_ch1))[*8] |->
		signal_ch1 == sig_present_ch1) else $error("lane 1 detect wrong");
	a_ch12_active_low: assert property ((sig_present_ch12_n == $past(sig_present_ch12_n))[*8] |->
		signal_ch12 == !sig_present_ch12_n) else $error("lane 12 detect wrong");
	a_oe_needs_run: assert property ((!link_running)[*2] |-> !rx_output_enable)
		else $error("outputs enabled while stopped");
	c_take: cover property (tx_take);
	c_run: cover property ($rose(dev_reset_n));
	c_fault: cover property ($fell(laser_ok));
endmodule

bind optlink_host link_ctrl_checker link_ctrl_checker_inst (.clk, .resetn, .supply_good,
	.link_reset_req, .lane_unused, .line_rate, .tx_word, .tx_take, .laser_ok, .signal_ch1,
	.signal_ch12, .rate_too_high, .link_running, .tx_lane, .dev_reset_n, .rx_output_enable,
	.laser_ctrl_ok, .sig_present_ch1, .sig_present_ch12_n);

// ===== testbench/link_device_model.sv
/*
 * Behavioural transmitter and receiver pair on the far side of optlink_host.
 * Assumes clk as its time base, 100 cycles to a microsecond, fiber looped back.
 */
module link_device_model (
	// Time base and fault
	input  wire logic        clk,
	input  wire logic        laser_fault,
	// Pins from the host
	input  wire logic [11:0] tx_lane,
	input  wire logic        dev_reset_n,
	input  wire logic        sigdet_enable,
	input  wire logic        rx_output_enable,
	// Pins to the host
	output logic      [11:0] rx_lane,
	output logic             laser_ctrl_ok,
	output logic             sig_present_ch1,
	output logic             sig_present_ch12_n
);
	logic [12:0] acc [12];
	logic [11:0] shut;
	logic [11:0] light;
	logic [11:0] last = 12'h000;
	logic [4:0]  quiet [2] = '{5'h10, 5'h10};
	logic        det_on;

	// ==========
	// Alerters
	// A one adds 43 and a zero takes 57, so 57% ones balance and a steady one trips after 1 us.
	always_ff @(posedge clk) begin
		for (int i = 0; i < 12; i++) begin
			if (!dev_reset_n) begin
				acc[i]  <= 13'h0000;
				shut[i] <= 1'b0;
			end else begin
				// The sum stops above the trip level so a lane held high never wraps back on.
				acc[i] <= tx_lane[i] ?
					(acc[i] > 13'h10cc ? acc[i] : acc[i] + 13'h002b) :
					(acc[i] > 13'h0039 ? acc[i] - 13'h0039 : 13'h0000);
				if (acc[i] > 13'h10cc)
					shut[i] <= 1'b1;
				else if (acc[i] == 13'h0000)
					shut[i] <= 1'b0;
			end
		end
	end
	assign light = tx_lane & ~shut & {12{dev_reset_n}};
	assign rx_lane = rx_output_enable ? light : 12'h000;
	assign laser_ctrl_ok = dev_reset_n & ~laser_fault;

	// ==========
	// Signal detect
	// Activity is any change of light within 16 cycles; an open enable pin reads high.
	assign det_on = (sigdet_enable !== 1'b0);
	always @(posedge clk) begin
		last <= light;
		quiet[0] <= (last[0] != light[0]) ? 5'h00 : quiet[0] + {4'h0, ~quiet[0][4]};
		quiet[1] <= (last[11] != light[11]) ? 5'h00 : quiet[1] + {4'h0, ~quiet[1][4]};
	end
	assign sig_present_ch1 = !det_on | !quiet[0][4];
	assign sig_present_ch12_n = det_on & quiet[1][4];
endmodule

// ===== testbench/test_parallel_optical_link_ctrl.sv
/*
 * Self-checking bench: optlink_host against the behavioural device model.
 * Assumes the checker binds itself; runs a 100 MHz clock.
 */
module test_parallel_optical_link_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, resetn, supply_good, link_reset_req, sigdet_on, rx_on, disp_clear;
	logic        laser_fault, tx_take, rx_word_valid, laser_ok, signal_ch1, signal_ch12;
	logic        rate_too_high, link_running, dev_reset_n, sigdet_enable, rx_output_enable;
	logic        laser_ctrl_ok, sig_present_ch1, sig_present_ch12_n;
	logic [11:0] lane_unused, line_rate, tx_word, rx_word, lane_rate_low, tx_lane, rx_lane, w;
	int          failures, check_count, seed, n;

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	optlink_host optlink_host_inst (.clk, .resetn, .supply_good, .link_reset_req, .lane_unused,
		.line_rate, .sigdet_on, .rx_on, .disp_clear, .tx_word, .tx_take, .rx_word, .rx_word_valid,
		.laser_ok, .signal_ch1, .signal_ch12, .rate_too_high, .lane_rate_low, .link_running,
		.tx_lane, .dev_reset_n, .sigdet_enable, .rx_output_enable, .rx_lane, .laser_ctrl_ok,
		.sig_present_ch1, .sig_present_ch12_n);
	link_device_model link_device_model_inst (.clk, .laser_fault, .tx_lane, .dev_reset_n,
		.sigdet_enable, .rx_output_enable, .rx_lane, .laser_ctrl_ok, .sig_present_ch1,
		.sig_present_ch12_n);

	// ==========
	// Helpers
	task automatic check1(input string what, input logic exp, input logic got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic check12(input string what, input logic [11:0] exp, input logic [11:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic rate_high(input logic [11:0] r);
		return r > optlink_pkg::MAX_RATE_MBPS;
	endfunction
	// Ends at a falling edge so the caller reads settled outputs.
	task automatic send(input logic [11:0] v);
		@(posedge clk);
		tx_word <= v;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (tx_take !== 1'b1 && n < 20);
		if (tx_take !== 1'b1)
			failures++;
	endtask
	task automatic settle(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#200000;
		failures++;
		report_and_stop();
	end

	// ==========
	// Scenarios
	initial begin
		{failures, check_count, n} = '0;
		seed = 18229;
		{resetn, supply_good, link_reset_req, disp_clear, laser_fault} = '0;
		{sigdet_on, rx_on} = 2'b11;
		{lane_unused, tx_word} = '0;
		line_rate = 12'h0640;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		settle(2);
		check1("dev_reset_n", 1'b0, dev_reset_n);
		check1("sigdet_enable", 1'b1, sigdet_enable);
		check1("rx_output_enable", 1'b0, rx_output_enable);
		@(posedge clk);
		lane_unused <= 12'h020;
		supply_good <= 1'b1;
		n = 0;
		while (link_running !== 1'b1 && n < 3000) begin
			settle(1);
			n++;
		end
		check1("reset hold", 1'b1, n >= optlink_pkg::POR_HOLD_CYC);
		check1("link_running", 1'b1, link_running);
		settle(120);
		for (int i = 0; i < 6; i++) begin
			w = (i == 0) ? 12'h0640 : (i == 1) ? 12'h0641 : 12'($random(seed));
			@(posedge clk);
			line_rate <= w;
			settle(3);
			check1("rate_too_high", rate_high(w), rate_too_high);
		end
		@(posedge clk);
		line_rate <= 12'h0640;
		// Each word is followed by its inverse so no used lane builds excess ones.
		for (int i = 0; i < 10; i++) begin
			w = (i == 0) ? 12'hfff : 12'($random(seed));
			for (int k = 0; k < 2; k++) begin
				repeat (4) send(w);
				check12("rx_word", w & ~12'h020, rx_word);
				check1("rx_word_valid", 1'b1, rx_word_valid);
				w = ~w;
			end
		end
		@(posedge clk);
		{line_rate, disp_clear} <= {12'h0010, 1'b1};
		repeat (4) send(12'hfff);
		@(posedge clk);
		disp_clear <= 1'b0;
		settle(16);
		check12("lane_rate_low", 12'hfdf, lane_rate_low);
		@(posedge clk);
		{line_rate, disp_clear, tx_word} <= {12'h0640, 1'b1, 12'h000};
		settle(40);
		check12("lane_rate_low", 12'h000, lane_rate_low);
		check1("signal_ch1", 1'b0, signal_ch1);
		check1("signal_ch12", 1'b0, signal_ch12);
		@(posedge clk);
		{disp_clear, laser_fault} <= 2'b01;
		settle(10);
		check1("laser_ok", 1'b0, laser_ok);
		@(posedge clk);
		{laser_fault, sigdet_on} <= 2'b00;
		settle(10);
		check1("laser_ok", 1'b1, laser_ok);
		check1("signal_ch1", 1'b1, signal_ch1);
		check1("signal_ch12", 1'b1, signal_ch12);
		@(posedge clk);
		sigdet_on <= 1'b1;
		for (int k = 0; k < 4; k++)
			send(k[0] ? 12'h000 : 12'h801);
		check1("signal_ch1", 1'b1, signal_ch1);
		check1("signal_ch12", 1'b1, signal_ch12);
		@(posedge clk);
		rx_on <= 1'b0;
		settle(4);
		check1("rx_output_enable", 1'b0, rx_output_enable);
		send(12'h000);
		check1("rx_word_valid", 1'b0, rx_word_valid);
		@(posedge clk);
		link_reset_req <= 1'b1;
		settle(4);
		check1("dev_reset_n", 1'b0, dev_reset_n);
		settle(8);
		check1("laser_ok", 1'b0, laser_ok);
		report_and_stop();
	end
endmodule
